// ---- window_detector_defs.svh ----
// Constants for the converter window detector
`ifndef WINDOW_DETECTOR_DEFS_SVH
`define WINDOW_DETECTOR_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LOWER_LIMIT_LOW_ADDR   8'hC6
`define LOWER_LIMIT_HIGH_ADDR  8'hC7
`define UPPER_LIMIT_LOW_ADDR   8'hC4
`define UPPER_LIMIT_HIGH_ADDR  8'hC5
`define CONTROL_ADDR           8'hE8
`define RESULT_LOW_ADDR        8'hBE
`define RESULT_HIGH_ADDR       8'hBF

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define UPPER_LIMIT_RESET      8'hFF
`define LOWER_LIMIT_RESET      8'h00
`define CONTROL_RESET          8'h00
`define WINDOW_FLAG_BIT        1
`define LEFT_JUSTIFY_BIT       0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CONVERSION_SAR_CLOCKS  16

`endif

// ---- window_detector_pkg.sv ----
// Types shared by the window detector files
package window_detector_pkg;

  // One finished conversion
  typedef struct packed {
    logic       valid;
    logic       differential;
    logic [9:0] code;
  } conversion_t;

  // Register access strobe
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_access_t;

  // Formatter state
  typedef enum logic [0:0] {
    IDLE_S   = 1'b0,
    FORMAT_S = 1'b1
  } format_state_t;

endpackage

// ---- result_formatter.sv ----
// Places a 10-bit conversion code into the 16-bit result word
`timescale 1ns/1ps
`include "window_detector_defs.svh"

module result_formatter
  import window_detector_pkg::*;
(
  // Conversion in
  input  wire logic        differential_in,
  input  wire logic [9:0]  code_in,
  input  wire logic        left_justify_in,
  // Formatted word out
  output logic      [15:0] word_out
);

  // ----------------------------------------
  // Justification
  // ----------------------------------------
  // Right form sign-extends for differential, zero-fills otherwise
  wire        ext_bit     = differential_in & code_in[9];
  wire [15:0] right_word  = {{6{ext_bit}}, code_in};
  // Left form: unused low bits read zero
  wire [15:0] left_word   = {code_in, 6'h00};

  assign word_out = left_justify_in ? left_word : right_word;

endmodule

// ---- window_detector.sv ----
// Window comparator on converter results with limit and control registers
`timescale 1ns/1ps
`include "window_detector_defs.svh"

module window_detector
  import window_detector_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // Special function register port
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  // Conversion result path
  input  wire logic        conv_start_in,
  input  wire logic        sar_tick_in,
  input  wire logic        conv_done_in,
  input  wire logic        differential_in,
  input  wire logic [9:0]  code_in,
  // Status
  output logic             window_match_flag_out,
  output logic             window_event_out,
  output logic      [15:0] result_word_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  upper_limit_high_byte;
  logic [7:0]  upper_limit_low_byte;
  logic [7:0]  lower_limit_high_byte;
  logic [7:0]  lower_limit_low_byte;
  logic [7:0]  converter_control_register;
  logic [15:0] result_word;
  logic        window_event;
  logic [4:0]  sar_count;
  logic        converting;
  logic        diff_latched;

  reg_access_t acc;
  assign acc = '{write: reg_write_in, read: reg_read_in,
                 addr: reg_addr_in, data: reg_wdata_in};

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_gth  = acc.write && acc.addr == `UPPER_LIMIT_HIGH_ADDR;
  wire wr_gtl  = acc.write && acc.addr == `UPPER_LIMIT_LOW_ADDR;
  wire wr_lth  = acc.write && acc.addr == `LOWER_LIMIT_HIGH_ADDR;
  wire wr_ltl  = acc.write && acc.addr == `LOWER_LIMIT_LOW_ADDR;
  wire wr_ctrl = acc.write && acc.addr == `CONTROL_ADDR;

  wire left_justify_select = converter_control_register[`LEFT_JUSTIFY_BIT];
  wire window_match_flag   = converter_control_register[`WINDOW_FLAG_BIT];

  // ----------------------------------------
  // Format and compare
  // ----------------------------------------
  logic [15:0] formatted;
  result_formatter u_fmt (
    .differential_in (differential_in),
    .code_in         (code_in),
    .left_justify_in (left_justify_select),
    .word_out        (formatted)
  );

  wire [15:0] upper_word = {upper_limit_high_byte, upper_limit_low_byte};
  wire [15:0] lower_word = {lower_limit_high_byte, lower_limit_low_byte};

  // Signed only for differential; single-ended stays unsigned
  function automatic logic less_than(input logic [15:0] a, input logic [15:0] b,
                                     input logic sgn);
    less_than = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  wire sgn        = differential_in;
  wire above_up   = less_than(upper_word, formatted, sgn);
  wire below_low  = less_than(formatted, lower_word, sgn);
  wire inverted   = less_than(upper_word, lower_word, sgn);
  // Inverted limits flag the inside, otherwise the outside
  // Equal limits fall to outside mode, so every other result matches
  wire match      = inverted ? (above_up && below_low)
                             : (above_up || below_low);

  // A result only counts once sixteen SAR clocks have elapsed
  wire result_ok  = conv_done_in && sar_count >= 5'(`CONVERSION_SAR_CLOCKS);
  wire next_event = result_ok && match;

  // ----------------------------------------
  // Conversion length guard
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      converting <= 1'b0;
      sar_count  <= 5'h00;
    end else if (conv_start_in) begin
      converting <= 1'b1;
      sar_count  <= 5'h00;
    end else if (conv_done_in) begin
      converting <= 1'b0;
    end else if (converting && sar_tick_in && sar_count != 5'h1F) begin
      sar_count  <= sar_count + 5'h01;
    end
  end

  // ----------------------------------------
  // Limit registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      upper_limit_high_byte <= `UPPER_LIMIT_RESET;
      upper_limit_low_byte  <= `UPPER_LIMIT_RESET;
      lower_limit_high_byte <= `LOWER_LIMIT_RESET;
      lower_limit_low_byte  <= `LOWER_LIMIT_RESET;
    end else begin
      if (wr_gth) upper_limit_high_byte <= acc.data;
      if (wr_gtl) upper_limit_low_byte  <= acc.data;
      if (wr_lth) lower_limit_high_byte <= acc.data;
      if (wr_ltl) lower_limit_low_byte  <= acc.data;
    end
  end

  // ----------------------------------------
  // Control register with sticky match flag
  // ----------------------------------------
  // A match in the clearing cycle wins, so no event is lost
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      converter_control_register <= `CONTROL_RESET;
    end else begin
      if (wr_ctrl) converter_control_register <= acc.data;
      if (next_event)
        converter_control_register[`WINDOW_FLAG_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      result_word  <= 16'h0000;
      window_event <= 1'b0;
      diff_latched <= 1'b0;
    end else begin
      window_event <= next_event;
      if (result_ok) begin
        result_word  <= formatted;
        diff_latched <= differential_in;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    unique case (acc.addr)
      `UPPER_LIMIT_HIGH_ADDR: reg_rdata_out = upper_limit_high_byte;
      `UPPER_LIMIT_LOW_ADDR:  reg_rdata_out = upper_limit_low_byte;
      `LOWER_LIMIT_HIGH_ADDR: reg_rdata_out = lower_limit_high_byte;
      `LOWER_LIMIT_LOW_ADDR:  reg_rdata_out = lower_limit_low_byte;
      `CONTROL_ADDR:          reg_rdata_out = converter_control_register;
      `RESULT_HIGH_ADDR:      reg_rdata_out = result_word[15:8];
      `RESULT_LOW_ADDR:       reg_rdata_out = result_word[7:0];
      default:                reg_rdata_out = 8'h00;
    endcase
  end

  assign window_match_flag_out = window_match_flag;
  assign window_event_out      = window_event;
  assign result_word_out       = result_word;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  // Qualified conversion that lands inside the flagged region
  sequence match_seen_s;
    conv_done_in && sar_count >= 5'd16 && match;
  endsequence
  // Software clear of the flag with no competing match
  sequence software_clear_s;
    wr_ctrl && !acc.data[`WINDOW_FLAG_BIT] && !next_event;
  endsequence

  flag_sets_a:
    assert property (match_seen_s |=> window_match_flag_out)
    else $error("match flag not set after match");
  flag_sticky_a:
    assert property (window_match_flag_out && !wr_ctrl |=> window_match_flag_out)
    else $error("match flag cleared by hardware");
  flag_clear_a:
    assert property (software_clear_s |=> !window_match_flag_out)
    else $error("software clear of match flag ignored");
  event_pulse_a:
    assert property (match_seen_s |=> window_event_out ##0 window_match_flag_out)
    else $error("event and flag disagree");
  short_conv_a:
    assert property (conv_done_in && sar_count < 5'd16 |=> !window_event_out)
    else $error("short conversion produced event");
  inside_mode_a:
    assert property (result_ok && inverted && !(above_up && below_low) |=> !window_event_out)
    else $error("inside mode flagged outside");
  outside_mode_a:
    assert property (result_ok && !inverted && (above_up || below_low) |=> window_event_out)
    else $error("outside mode missed a match");
  left_zero_a:
    assert property (result_ok && left_justify_select |=> result_word_out[5:0] == 6'h00)
    else $error("left justified low bits not zero");
  sign_ext_a:
    assert property (result_ok && !left_justify_select |=>
      result_word_out[15:10] == {6{diff_latched & result_word_out[9]}})
    else $error("right justified extension wrong");
  limit_write_a:
    assert property (wr_gth |=> upper_limit_high_byte == $past(reg_wdata_in))
    else $error("upper high byte not written");
  lower_write_a:
    assert property (wr_ltl |=> lower_limit_low_byte == $past(reg_wdata_in))
    else $error("lower low byte not written");
  // Reset checks must run while reset is high, so the default disable is lifted
  reset_limits_a:
    assert property (disable iff (1'b0) srst_in |=>
      upper_word == {2{`UPPER_LIMIT_RESET}} && lower_word == {2{`LOWER_LIMIT_RESET}})
    else $error("limit words not at reset values");
  reset_status_a:
    assert property (disable iff (1'b0) srst_in |=>
      !window_match_flag_out && !window_event_out && result_word_out == 16'h0000)
    else $error("status not cleared by reset");

endmodule

// ---- converter_model.sv ----
// Converter model that runs one conversion per request
`timescale 1ns/1ps

module converter_model (
  // Clock and request
  input  wire logic       clock_in,
  input  wire logic       go_in,
  input  wire logic [4:0] ticks_in,
  input  wire logic       diff_in,
  input  wire logic [9:0] value_in,
  // Converter side of the detector
  output logic            start_out,
  output logic            tick_out,
  output logic            done_out,
  output logic            differential_out,
  output logic [9:0]      code_out,
  output logic            busy_out
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Code lines are only qualified by done, so they show garbage outside it
  initial begin
    {start_out, tick_out, done_out, differential_out, busy_out} = '0;
    code_out = 10'h3FF;
    forever begin
      @(posedge clock_in iff go_in);
      busy_out = 1'b1;
      #1 start_out = 1'b1;
      repeat (ticks_in) begin
        @(posedge clock_in);
        #1 start_out = 1'b0;
        tick_out = 1'b1;
      end
      @(posedge clock_in);
      #1 tick_out = 1'b0;
      done_out = 1'b1;
      differential_out = diff_in;
      code_out = value_in;
      @(posedge clock_in);
      #1 done_out = 1'b0;
      code_out = ~value_in;
      differential_out = ~diff_in;
      busy_out = 1'b0;
    end
  end
endmodule

// ---- window_detector_test.sv ----
// Self-checking bench for the window detector
`timescale 1ns/1ps
`include "window_detector_defs.svh"

module window_detector_test;
  logic        clock_in, srst_in, we, re, go, dv, lj, ev, flag, st, tk, dn, df, busy;
  logic [7:0]  ad, wd, rdata;
  logic [4:0]  nt;
  logic [9:0]  cv, code;
  logic [15:0] word, last_w;
  int          err_count, comparisons;

  window_detector dut_u (.clock_in(clock_in), .srst_in(srst_in), .reg_write_in(we),
    .reg_read_in(re), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdata),
    .conv_start_in(st), .sar_tick_in(tk), .conv_done_in(dn), .differential_in(df),
    .code_in(code), .window_match_flag_out(flag), .window_event_out(ev),
    .result_word_out(word));
  converter_model model_u (.clock_in(clock_in), .go_in(go), .ticks_in(nt), .diff_in(dv),
    .value_in(cv), .start_out(st), .tick_out(tk), .done_out(dn), .differential_out(df),
    .code_out(code), .busy_out(busy));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1 we = 1'b1;
    ad = a;
    wd = d;
    @(posedge clock_in);
    #1 we = 1'b0;
  endtask
  // Read data is combinational, so it is judged before the edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    #1 re = 1'b1;
    ad = a;
    #1 chk({8'h00, rdata}, {8'h00, e});
    @(posedge clock_in);
    #1 re = 1'b0;
  endtask
  task automatic lim(input logic [15:0] u, input logic [15:0] l);
    wr(`UPPER_LIMIT_LOW_ADDR, u[7:0]);
    wr(`UPPER_LIMIT_HIGH_ADDR, u[15:8]);
    wr(`LOWER_LIMIT_LOW_ADDR, l[7:0]);
    wr(`LOWER_LIMIT_HIGH_ADDR, l[15:8]);
  endtask
  // Short conversions must leave the held word alone
  task automatic conv(input logic d, input logic [9:0] c, input logic [4:0] n, input logic m);
    int k;
    @(posedge clock_in);
    #1 go = 1'b1;
    dv = d;
    cv = c;
    nt = n;
    @(posedge clock_in);
    #1 go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 60) begin
      @(posedge clock_in);
      #2 k++;
    end
    chk({15'h0000, k >= 60}, 16'h0000);
    if (n >= 5'd16) last_w = lj ? {c, 6'h00} : {{6{d & c[9]}}, c};
    chk(word, last_w);
    chk({15'h0000, ev}, {15'h0000, m});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`UPPER_LIMIT_LOW_ADDR, 8'hFF);
    rd(`UPPER_LIMIT_HIGH_ADDR, 8'hFF);
    rd(`LOWER_LIMIT_LOW_ADDR, 8'h00);
    rd(`LOWER_LIMIT_HIGH_ADDR, 8'h00);
    rd(`CONTROL_ADDR, 8'h00);
    chk(word, 16'h0000);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_format;
    conv(1'b0, 10'h2C5, 5'd16, 1'b0);
    conv(1'b1, 10'h2C5, 5'd16, 1'b0);
    rd(`RESULT_HIGH_ADDR, 8'hFE);
    rd(`RESULT_LOW_ADDR, 8'hC5);
    wr(`CONTROL_ADDR, 8'h01);
    lj = 1'b1;
    conv(1'b0, 10'h2C5, 5'd16, 1'b0);
    conv(1'b1, 10'h2C5, 5'd16, 1'b0);
    rd(`RESULT_HIGH_ADDR, 8'hB1);
    rd(`RESULT_LOW_ADDR, 8'h40);
    wr(`CONTROL_ADDR, 8'h00);
    lj = 1'b0;
  endtask
  task automatic t_outside;
    lim(16'h02A5, 16'h013C);
    rd(`UPPER_LIMIT_LOW_ADDR, 8'hA5);
    rd(`LOWER_LIMIT_HIGH_ADDR, 8'h01);
    conv(1'b0, 10'h180, 5'd16, 1'b0);
    conv(1'b0, 10'h300, 5'd16, 1'b1);
    conv(1'b0, 10'h2A5, 5'd16, 1'b0);
    conv(1'b0, 10'h13B, 5'd16, 1'b1);
    chk({15'h0000, flag}, 16'h0001);
    rd(`CONTROL_ADDR, 8'h02);
    wr(`CONTROL_ADDR, 8'h00);
    chk({15'h0000, flag}, 16'h0000);
  endtask
  task automatic t_inside;
    lim(16'h0100, 16'h0200);
    conv(1'b0, 10'h300, 5'd16, 1'b0);
    conv(1'b0, 10'h180, 5'd16, 1'b1);
    lim(16'h0000, 16'hFFF0);
    conv(1'b1, 10'h3FF, 5'd16, 1'b0);
    conv(1'b1, 10'h3E0, 5'd16, 1'b1);
    conv(1'b1, 10'h001, 5'd16, 1'b1);
  endtask
  task automatic t_short;
    conv(1'b0, 10'h3FF, 5'd15, 1'b0);
    conv(1'b0, 10'h3FF, 5'd16, 1'b1);
  endtask
  // Mid-run reset with flag set and limits moved must restore everything
  task automatic t_rereset;
    @(posedge clock_in);
    #1 srst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1 srst_in = 1'b0;
    last_w = 16'h0000;
    chk({15'h0000, flag}, 16'h0000);
    t_reset;
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic results;
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Free-running 4 ns clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // Whole run is about four hundred cycles; the limit here is ten thousand
  initial begin
    #40000 err_count++;
    results;
  end
  // Stimulus: reset, then every scenario in turn
  initial begin
    {we, re, go, dv, lj, ad, wd, nt, cv, last_w} = '0;
    srst_in = 1'b1;
    repeat (16) @(posedge clock_in);
    #1 srst_in = 1'b0;
    t_reset;
    t_format;
    t_outside;
    t_inside;
    t_short;
    t_rereset;
    results;
  end
endmodule
